// *** hdl/cdr_pkg.sv ***
// constants, register map and carrier types of the cdr acquisition loop control block
package cdr_pkg;

   // ****************************************************************
   // register offsets
   // ****************************************************************
   localparam logic [7:0] REG_EDGE_BW      = 8'h10;
   localparam logic [7:0] REG_SLICE_LOOP   = 8'h13;
   localparam logic [7:0] REG_SAMPLE_PHASE = 8'h14;
   localparam logic [7:0] REG_THRESHOLD    = 8'h15;
   localparam logic [7:0] REG_TRIM         = 8'h73;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int BW_LSB        = 0;
   localparam int EDGE_LSB      = 3;
   localparam int ADAPT_BIT     = 0;
   localparam int SLEW_LSB      = 1;
   localparam int PHASE_LSB     = 0;
   localparam int SLICE_EXT_BIT = 7;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0] RST_EDGE_BW      = 8'h04;
   localparam logic [7:0] RST_SLICE_LOOP   = 8'h05;
   localparam logic [7:0] RST_SAMPLE_PHASE = 8'h00;
   localparam logic [7:0] RST_THRESHOLD    = 8'h00;

   // ****************************************************************
   // lock detector, acquisition and slice figures
   // ****************************************************************
   localparam logic [47:0] PPM_SCALE    = 48'h0000000f4240;
   localparam logic [47:0] LOSE_PPM     = 48'h0000000003e8;
   localparam logic [47:0] LOCK_PPM     = 48'h0000000000fa;
   localparam int          NEAR_SHIFT   = 4;
   localparam logic [15:0] STEP_LARGE   = 16'h1000;
   localparam logic [6:0]  SLICE_MID    = 7'h40;
   localparam logic [2:0]  EXT_SCALE    = 3'h6;
   localparam logic [3:0]  DIV_EXP_MAX  = 4'hf;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {
      EDGE_BOTH    = 2'h0,
      EDGE_RISING  = 2'h1,
      EDGE_FALLING = 2'h2,
      EDGE_RSVD    = 2'h3
   } cdr_edge_t;

   typedef struct packed {
      logic        sliceEnable;
      logic        sliceExtended;
      logic [6:0]  sliceCode;
      logic signed [10:0] sliceOffset;
      logic        adaptiveSliceEn;
      cdr_edge_t   edgeSel;
      logic [1:0]  dllSlew;
      logic signed [4:0] samplePhase;
      logic [2:0]  loopBandwidthScale;
   } cdr_settings_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] sampleCnt;
      logic [15:0] dataCnt;
   } cdr_meas_t;

endpackage

// *** hdl/cdr_fifo.sv ***
// small fifo for recovered data words with registered flags
`timescale 1ns/1ps
`default_nettype none
module cdr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             mclk,       // clock
   input  wire logic             rstn,       // synchronised reset
   input  wire logic             fillEnable, // allows filling
   input  wire logic [WIDTH-1:0] inData,     // write word
   input  wire logic             inValid,    // write request
   output logic                  inReady,    // space and filling enabled
   output logic [WIDTH-1:0]      outData,    // head word
   output logic                  outValid,   // head word present
   input  wire logic             outReady    // drain accepts
);
   localparam int AW = $clog2(DEPTH);

   // ****************************************************************
   // storage and pointers
   // ****************************************************************
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr, rdPtr, next_wrPtr, next_rdPtr;
   logic [AW:0]      count, next_count;
   logic             next_inReady, next_outValid;
   logic             doWr, doRd;

   always_comb begin
      doWr = inValid & inReady;
      doRd = outValid & outReady;
      next_wrPtr = doWr ? ((wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1) : wrPtr;
      next_rdPtr = doRd ? ((rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1) : rdPtr;
      next_count = count + {{AW{1'b0}}, doWr} - {{AW{1'b0}}, doRd};
      next_inReady  = fillEnable & (next_count != (AW+1)'(DEPTH));
      next_outValid = next_count != '0;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wrPtr    <= '0;
         rdPtr    <= '0;
         count    <= '0;
         inReady  <= 1'b0;
         outValid <= 1'b0;
      end else begin
         wrPtr    <= next_wrPtr;
         rdPtr    <= next_rdPtr;
         count    <= next_count;
         inReady  <= next_inReady;
         outValid <= next_outValid;
      end
   end

   always_ff @(posedge mclk) begin
      if (doWr) begin
         mem[wrPtr] <= inData;
      end
   end

   assign outData = mem[rdPtr];
endmodule
`default_nettype wire

// *** hdl/cdr_loop_ctrl.sv ***
// acquisition loop control, lock detector and setting registers of the clock and data recovery
// Function
// - lose lock beyond 1000 ppm, restart
// - restart: oscillator bottom, division ratio one
// - double ratio if fast at oscillator bottom, lower oscillator if fast above it, else raise oscillator
// - shrinking steps; clear lock-lost within 250 ppm
// - lock clears frequency loop enable
// - seven-bit slice code offsets quantizer
// - trimmed offset readable, seven bits, read-only
// - normal: zero disables, 64 means none
// - extended bit scales slice range sixfold
// - adaptive slice enable bit gates offset loop
// - edge select: rising one, falling two
// - slew field, default two, sets tracking
// - slew zero lowers jitter generation
// - sample phase works only at high rate
// - sample phase is signed, 1/32 UI steps
// - bandwidth scale field, reset four
// - bandwidth above four allowed, discouraged
// - hysteresis between 250 and 1000 ppm
`timescale 1ns/1ps
`default_nettype none
module cdr_loop_ctrl #(
   parameter int DATA_W     = 8,
   parameter int FIFO_DEPTH = 8,
   parameter int OSC_W      = 16
) (
   input  wire logic                  mclk,               // recovered oscillator clock
   input  wire logic                  resetn,             // asynchronous reset, active low
   input  wire logic [7:0]            regAddr,            // register port address
   input  wire logic [7:0]            regWrData,          // register port write byte
   input  wire logic                  regWr,              // register write strobe
   input  wire logic                  regRd,              // register read strobe
   output logic [7:0]                 regRdData,          // read byte
   output logic                       regRdValid,         // read byte valid pulse
   input  wire logic [6:0]            trimOffset,         // factory trimmed offset
   input  wire logic                  rateHigh,           // data rate at or above 5.65 Gbps
   input  wire cdr_pkg::cdr_meas_t    meas,               // frequency measurement
   output logic [OSC_W-1:0]           tunableOscillator,  // oscillator control word
   output logic [3:0]                 divExp,             // division ratio exponent
   output logic                       lockLostFlag,       // loss of lock
   output logic                       fllEnable,          // frequency loop active
   output cdr_pkg::cdr_settings_t     settings,           // quantizer and loop settings
   input  wire logic [DATA_W-1:0]     inData,             // sampled data word
   input  wire logic                  inValid,            // sampled word valid
   output logic                       inReady,            // sampled word accepted
   output logic [DATA_W-1:0]          outData,            // recovered data word
   output logic                       outValid,           // recovered word valid
   input  wire logic                  outReady            // recovered word taken
);

   // ****************************************************************
   // reset release
   // ****************************************************************
   logic rstMeta, rstn;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rstMeta <= 1'b0;
         rstn    <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstn    <= rstMeta;
      end
   end

   // ****************************************************************
   // register file
   // ****************************************************************
   logic [7:0] edgeBw, sliceLoop, phaseReg, thresh;
   logic [7:0] next_edgeBw, next_sliceLoop, next_phaseReg, next_thresh;
   logic [7:0] next_regRdData;
   logic       next_regRdValid;

   always_comb begin
      next_edgeBw    = edgeBw;
      next_sliceLoop = sliceLoop;
      next_phaseReg  = phaseReg;
      next_thresh    = thresh;
      if (regWr) begin
         unique case (regAddr)
            cdr_pkg::REG_EDGE_BW:      next_edgeBw    = regWrData;
            cdr_pkg::REG_SLICE_LOOP:   next_sliceLoop = regWrData;
            cdr_pkg::REG_SAMPLE_PHASE: next_phaseReg  = regWrData;
            cdr_pkg::REG_THRESHOLD:    next_thresh    = regWrData;
            default:                   next_edgeBw    = edgeBw;
         endcase
      end
      next_regRdValid = regRd;
      next_regRdData  = 8'h00;
      if (regRd) begin
         unique case (regAddr)
            cdr_pkg::REG_EDGE_BW:      next_regRdData = edgeBw;
            cdr_pkg::REG_SLICE_LOOP:   next_regRdData = sliceLoop;
            cdr_pkg::REG_SAMPLE_PHASE: next_regRdData = phaseReg;
            cdr_pkg::REG_THRESHOLD:    next_regRdData = thresh;
            cdr_pkg::REG_TRIM:         next_regRdData = {1'b0, trimOffset};
            default:                   next_regRdData = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         edgeBw     <= cdr_pkg::RST_EDGE_BW;
         sliceLoop  <= cdr_pkg::RST_SLICE_LOOP;
         phaseReg   <= cdr_pkg::RST_SAMPLE_PHASE;
         thresh     <= cdr_pkg::RST_THRESHOLD;
         regRdData  <= 8'h00;
         regRdValid <= 1'b0;
      end else begin
         edgeBw     <= next_edgeBw;
         sliceLoop  <= next_sliceLoop;
         phaseReg   <= next_phaseReg;
         thresh     <= next_thresh;
         regRdData  <= next_regRdData;
         regRdValid <= next_regRdValid;
      end
   end

   // ****************************************************************
   // decoded settings
   // ****************************************************************
   cdr_pkg::cdr_settings_t next_settings;
   logic [6:0]             code;
   logic signed [7:0]      centred;
   logic [3:0]             phaseField;

   always_comb begin
      code       = thresh[6:0];
      centred    = $signed({1'b0, code}) - $signed({1'b0, cdr_pkg::SLICE_MID});
      phaseField = phaseReg[cdr_pkg::PHASE_LSB +: 4];
      next_settings.sliceCode     = code;
      next_settings.sliceEnable   = code != 7'h00;
      next_settings.sliceExtended = thresh[cdr_pkg::SLICE_EXT_BIT];
      if (code == 7'h00) begin
         next_settings.sliceOffset = 11'sh000;
      end else if (thresh[cdr_pkg::SLICE_EXT_BIT]) begin
         next_settings.sliceOffset = 11'(centred * $signed({1'b0, cdr_pkg::EXT_SCALE}));
      end else begin
         next_settings.sliceOffset = 11'(centred);
      end
      next_settings.adaptiveSliceEn = sliceLoop[cdr_pkg::ADAPT_BIT];
      next_settings.edgeSel = cdr_pkg::cdr_edge_t'(edgeBw[cdr_pkg::EDGE_LSB +: 2]);
      next_settings.dllSlew = sliceLoop[cdr_pkg::SLEW_LSB +: 2];
      // phase shift is held at zero below the high rate band
      next_settings.samplePhase = rateHigh ? $signed({phaseField[3], phaseField}) : 5'sh00;
      next_settings.loopBandwidthScale = edgeBw[cdr_pkg::BW_LSB +: 3];
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         settings <= '0;
      end else begin
         settings <= next_settings;
      end
   end

   // ****************************************************************
   // frequency acquisition
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_RESTART = 3'h1,
      ST_MEASURE = 3'h2,
      ST_LOCKED  = 3'h4
   } cdr_state_t;

   cdr_state_t       state, next_state;
   logic [OSC_W-1:0] step, next_step, next_osc;
   logic [3:0]       next_divExp;
   logic             next_lockLost, next_fll;
   logic             fast;
   logic [15:0]      diff;
   logic [47:0]      diffPpm, lockLimit, loseLimit;
   logic             withinLock, beyondLose, nearData;

   always_comb begin
      fast       = meas.sampleCnt > meas.dataCnt;
      diff       = fast ? meas.sampleCnt - meas.dataCnt : meas.dataCnt - meas.sampleCnt;
      diffPpm    = {32'h0, diff} * cdr_pkg::PPM_SCALE;
      lockLimit  = {32'h0, meas.dataCnt} * cdr_pkg::LOCK_PPM;
      loseLimit  = {32'h0, meas.dataCnt} * cdr_pkg::LOSE_PPM;
      withinLock = diffPpm <= lockLimit;
      beyondLose = diffPpm > loseLimit;
      nearData   = diff < (meas.dataCnt >> cdr_pkg::NEAR_SHIFT);
      next_state    = state;
      next_step     = step;
      next_osc      = tunableOscillator;
      next_divExp   = divExp;
      next_lockLost = lockLostFlag;
      next_fll      = fllEnable;
      unique case (state)
         ST_RESTART: begin
            next_osc      = '0;
            next_divExp   = 4'h0;
            next_step     = OSC_W'(cdr_pkg::STEP_LARGE);
            next_lockLost = 1'b1;
            next_fll      = 1'b1;
            next_state    = ST_MEASURE;
         end
         ST_MEASURE: begin
            if (meas.valid) begin
               if (withinLock) begin
                  next_lockLost = 1'b0;
                  next_fll      = 1'b0;
                  next_state    = ST_LOCKED;
               end else if (fast) begin
                  if (tunableOscillator == '0) begin
                     if (divExp != cdr_pkg::DIV_EXP_MAX) begin
                        next_divExp = divExp + 4'h1;
                     end
                  end else begin
                     // overshoot: back off by a smaller step
                     next_step = (step > OSC_W'(1)) ? step >> 1 : step;
                     next_osc  = (tunableOscillator > next_step) ? tunableOscillator - next_step : '0;
                  end
               end else begin
                  if (nearData && step > OSC_W'(1)) begin
                     next_step = step >> 1;
                  end
                  if (tunableOscillator <= ~next_step) begin
                     next_osc = tunableOscillator + next_step;
                  end
               end
            end
         end
         ST_LOCKED: begin
            if (meas.valid && beyondLose) begin
               next_lockLost = 1'b1;
               next_fll      = 1'b1;
               next_osc      = '0;
               next_divExp   = 4'h0;
               next_state    = ST_RESTART;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state             <= ST_RESTART;
         step              <= '0;
         tunableOscillator <= '0;
         divExp            <= 4'h0;
         lockLostFlag      <= 1'b1;
         fllEnable         <= 1'b1;
      end else begin
         state             <= next_state;
         step              <= next_step;
         tunableOscillator <= next_osc;
         divExp            <= next_divExp;
         lockLostFlag      <= next_lockLost;
         fllEnable         <= next_fll;
      end
   end

   // ****************************************************************
   // recovered data path
   // ****************************************************************
   // words are only accepted while locked, stored words still drain; the source stalls otherwise
   cdr_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) dataFifo (
      .mclk       (mclk),
      .rstn       (rstn),
      .fillEnable (~next_lockLost),
      .inData     (inData),
      .inValid    (inValid),
      .inReady    (inReady),
      .outData    (outData),
      .outValid   (outValid),
      .outReady   (outReady)
   );
endmodule
`default_nettype wire

// *** tb/cdr_loop_ctrl_assertions.sv ***
// concurrent checks on the ports of the loop control block
`timescale 1ns/1ps
`default_nettype none
module cdr_loop_ctrl_assertions #(
   parameter int DATA_W     = 8,
   parameter int FIFO_DEPTH = 8,
   parameter int OSC_W      = 16
) (
   input wire logic                   mclk,              // clock
   input wire logic                   resetn,            // reset, active low
   input wire logic [7:0]             regAddr,           // address
   input wire logic [7:0]             regWrData,         // write byte
   input wire logic                   regWr,             // write strobe
   input wire logic                   regRd,             // read strobe
   input wire logic [7:0]             regRdData,         // read byte
   input wire logic                   regRdValid,        // read valid
   input wire logic [6:0]             trimOffset,        // trim value
   input wire logic                   rateHigh,          // high rate
   input wire cdr_pkg::cdr_meas_t     meas,              // measurement
   input wire logic [OSC_W-1:0]       tunableOscillator, // oscillator word
   input wire logic [3:0]             divExp,            // division exponent
   input wire logic                   lockLostFlag,      // loss of lock
   input wire logic                   fllEnable,         // frequency loop on
   input wire cdr_pkg::cdr_settings_t settings,          // settings
   input wire logic [DATA_W-1:0]      inData,            // fifo in word
   input wire logic                   inValid,           // fifo in valid
   input wire logic                   inReady,           // fifo in ready
   input wire logic [DATA_W-1:0]      outData,           // fifo out word
   input wire logic                   outValid,          // fifo out valid
   input wire logic                   outReady           // fifo out ready
);
   logic [7:0] wrByte;
   logic       mapped;
   always_ff @(posedge mclk) wrByte <= regWrData;
   always_comb mapped = regAddr inside {cdr_pkg::REG_EDGE_BW, cdr_pkg::REG_SLICE_LOOP, cdr_pkg::REG_SAMPLE_PHASE,
                                        cdr_pkg::REG_THRESHOLD, cdr_pkg::REG_TRIM};
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // ****************************************************************
   // register port, settings, acquisition and fifo
   // ****************************************************************
   rd_pulse_a: assert property (regRdValid == $past(regRd))
      else $error("read valid not one cycle after read strobe");
   rd_idle_a: assert property (!regRdValid |-> regRdData == 8'h00)
      else $error("read data not zero outside valid");
   trim_read_a: assert property (regRd && regAddr == cdr_pkg::REG_TRIM |=> regRdData == {1'b0, $past(trimOffset)})
      else $error("trim readback wrong");
   unmapped_a: assert property (regRd && !mapped |=> regRdData == 8'h00)
      else $error("unmapped read not zero");
   slice_write_a: assert property (regWr && regAddr == cdr_pkg::REG_THRESHOLD |=> ##1
      {settings.sliceExtended, settings.sliceCode} == $past(wrByte)) else $error("slice setting not applied");
   slice_scale_a: assert property (settings.sliceOffset == (settings.sliceCode == 7'h00 ? 11'h0 :
      ({4'h0, settings.sliceCode} - 11'h40) * (settings.sliceExtended ? 11'h6 : 11'h1))) else $error("slice offset wrong");
   phase_gate_a: assert property (!$past(rateHigh) |-> settings.samplePhase == 5'sh0)
      else $error("sample phase active at low rate");
   lock_pair_a: assert property (fllEnable == lockLostFlag)
      else $error("frequency loop enable disagrees with lock");
   lock_meas_a: assert property ($fell(lockLostFlag) |-> $past(meas.valid))
      else $error("lock gained without a measurement");
   restart_a: assert property ($rose(lockLostFlag) |-> tunableOscillator == '0 && divExp == 4'h0)
      else $error("restart did not clear oscillator and ratio");
   div_step_a: assert property ($changed(divExp) && divExp != 4'h0 |-> divExp == $past(divExp) + 4'h1)
      else $error("division ratio did not double");
   refuse_a: assert property (lockLostFlag |-> !inReady)
      else $error("fifo accepts while lock is lost");
endmodule
bind cdr_loop_ctrl cdr_loop_ctrl_assertions #(.DATA_W(DATA_W), .FIFO_DEPTH(FIFO_DEPTH), .OSC_W(OSC_W)) u_chk (
   .mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
   .regRdData(regRdData), .regRdValid(regRdValid), .trimOffset(trimOffset), .rateHigh(rateHigh), .meas(meas),
   .tunableOscillator(tunableOscillator), .divExp(divExp), .lockLostFlag(lockLostFlag), .fllEnable(fllEnable),
   .settings(settings), .inData(inData), .inValid(inValid), .inReady(inReady), .outData(outData),
   .outValid(outValid), .outReady(outReady));
`default_nettype wire

// *** tb/cdr_data_source.sv ***
// behavioural data source: frequency measurements and sampled words
`timescale 1ns/1ps
`default_nettype none
module cdr_data_source (
   input  wire logic        mclk,     // clock
   input  wire logic        measEn,   // measurements run
   input  wire logic [15:0] dataRate, // data count per window
   input  wire logic [15:0] osc,      // oscillator word
   input  wire logic [3:0]  divExp,   // division exponent
   output cdr_pkg::cdr_meas_t meas,   // measurement
   input  wire logic        wordEn,   // words offered
   output logic [7:0]       inData,   // word
   output logic             inValid,  // word valid
   input  wire logic        inReady   // word taken
);
   logic [1:0]  gap = 2'h0;
   initial meas = '0;
   initial inValid = 1'b0;
   always @(posedge mclk) begin
      gap <= gap + 2'h1;
      meas.valid <= measEn && gap == 2'h3;
      meas.sampleCnt <= 16'((32'h8000 + 32'(osc)) >> divExp);
      meas.dataCnt <= dataRate;
      // a word is held until taken; an idle bus shows changing values
      if (!inValid || inReady) begin
         inValid <= wordEn;
         inData <= 8'($urandom);
      end
   end
endmodule
`default_nettype wire

// *** tb/cdr_loop_ctrl_tb.sv ***
// self-checking bench for the loop control block with a reference model
`timescale 1ns/1ps
`default_nettype none
module cdr_loop_ctrl_tb;
   localparam logic [31:0] ADDRS = 32'h15141310;
   localparam logic [63:0] CODES = 64'hffc08180_7f400100;
   logic        mclk = 1'b0, resetn = 1'b0, regWr = 1'b0, regRd = 1'b0, rateHigh = 1'b0;
   logic        measEn = 1'b0, wordEn = 1'b0, outReady = 1'b0;
   logic        regRdValid, lockLostFlag, fllEnable, inValid, inReady, outValid;
   logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, regRdData, inData, outData, v;
   logic [6:0]  trimOffset = 7'h00;
   logic [15:0] dataRate = 16'h3000, tunableOscillator;
   logic [3:0]  divExp;
   logic [7:0]  sh [4] = '{cdr_pkg::RST_EDGE_BW, cdr_pkg::RST_SLICE_LOOP, cdr_pkg::RST_SAMPLE_PHASE, cdr_pkg::RST_THRESHOLD};
   logic [7:0]  q [$];
   int          fail_count = 0, compares = 0, pushes = 0, k, mOsc = 0, mDiv = 0, mStep = 4096, mLost = 1;
   cdr_pkg::cdr_meas_t     meas;
   cdr_pkg::cdr_settings_t settings, e;
   always #5 mclk = ~mclk;
   cdr_loop_ctrl u_dut (.mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .regRdValid(regRdValid), .trimOffset(trimOffset), .rateHigh(rateHigh),
      .meas(meas), .tunableOscillator(tunableOscillator), .divExp(divExp), .lockLostFlag(lockLostFlag),
      .fllEnable(fllEnable), .settings(settings), .inData(inData), .inValid(inValid), .inReady(inReady),
      .outData(outData), .outValid(outValid), .outReady(outReady));
   cdr_data_source u_src (.mclk(mclk), .measEn(measEn), .dataRate(dataRate), .osc(tunableOscillator),
      .divExp(divExp), .meas(meas), .wordEn(wordEn), .inData(inData), .inValid(inValid), .inReady(inReady));
   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic chk(string n, logic [39:0] ex, logic [39:0] got);
      compares++;
      if (got !== ex) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, ex, got);
      end
   endtask
   task automatic summarize;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] ex);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 chk("rdValid", 1, regRdValid);
      chk("rdData", ex, regRdData);
   endtask
   task automatic expect_settings;
      e = '0;
      e.sliceEnable = |sh[3][6:0];
      e.sliceExtended = sh[3][7];
      e.sliceCode = sh[3][6:0];
      if (e.sliceEnable) e.sliceOffset = 11'((int'(sh[3][6:0]) - 64) * (sh[3][7] ? 6 : 1));
      e.adaptiveSliceEn = sh[1][0];
      e.edgeSel = cdr_pkg::cdr_edge_t'(sh[0][4:3]);
      e.dllSlew = sh[1][2:1];
      if (rateHigh) e.samplePhase = 5'({sh[2][3], sh[2][3:0]});
      e.loopBandwidthScale = sh[0][2:0];
      chk("settings", e, settings);
   endtask
   task automatic step_model(int s, int d);
      longint df = s > d ? s - d : d - s;
      if (df * 1000000 <= longint'(d) * 250) mLost = 0;
      else if (!mLost) begin
         if (df * 1000000 > longint'(d) * 1000) begin
            mLost = 1;
            mOsc = 0;
            mDiv = 0;
            mStep = 4096;
         end
      end else if (s > d) begin
         if (mOsc == 0) mDiv = mDiv < 15 ? mDiv + 1 : 15;
         else begin
            mStep = mStep > 1 ? mStep / 2 : 1;
            mOsc = mOsc > mStep ? mOsc - mStep : 0;
         end
      end else begin
         if (df < d / 16) mStep = mStep > 1 ? mStep / 2 : 1;
         if (mOsc + mStep <= 65535) mOsc = mOsc + mStep;
      end
   endtask
   task automatic wait_lock(logic lvl);
      for (k = 0; k < 4000 && lockLostFlag !== lvl; k++) @(posedge mclk);
      if (k == 4000) begin
         fail_count++;
         summarize();
      end
   endtask
   // acquisition results are compared once the measurement edge has landed
   always @(posedge mclk) begin
      if (meas.valid) begin
         step_model(meas.sampleCnt, meas.dataCnt);
         @(negedge mclk);
         chk("osc", mOsc, tunableOscillator);
         chk("divExp", mDiv, divExp);
         chk("lockLost", mLost, lockLostFlag);
         chk("fllEnable", mLost, fllEnable);
      end
   end
   always @(posedge mclk) begin
      if (inValid && inReady) begin
         q.push_back(inData);
         pushes++;
      end
      if (outValid && outReady) begin
         if (q.size() == 0) chk("popEmpty", 0, 1);
         else chk("outData", q.pop_front(), outData);
      end
   end
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      void'($urandom(32'h081bd142));
      trimOffset <= 7'($urandom);
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      repeat (3) @(posedge mclk);
      for (int r = 0; r < 4; r++) rd(ADDRS[8*r +: 8], sh[r]);
      rd(cdr_pkg::REG_TRIM, {1'b0, trimOffset});
      wr(cdr_pkg::REG_TRIM, 8'hff);
      rd(cdr_pkg::REG_TRIM, {1'b0, trimOffset});
      rd(8'h20, 8'h00);
      for (int i = 0; i < 32; i++) begin
         v = (i % 4 == 3) ? CODES[8*(i/4) +: 8] : 8'($urandom);
         if (i % 4 == 0 && v[2:0] == 3'h0) v[2:0] = 3'h4;
         rateHigh <= i[2];
         sh[i % 4] = v;
         wr(ADDRS[8*(i%4) +: 8], v);
         @(posedge mclk);
         #1 expect_settings();
         rd(ADDRS[8*(i%4) +: 8], v);
      end
      measEn <= 1'b1;
      wait_lock(1'b0);
      wordEn <= 1'b1;
      for (k = 0; k < 100 && inReady !== 1'b0; k++) @(posedge mclk);
      repeat (4) @(posedge mclk);
      chk("filled", 8, pushes);
      wordEn <= 1'b0;
      for (k = 0; k < 300 && (q.size() != 0 || outValid !== 1'b0); k++) begin
         @(posedge mclk);
         outReady <= 1'($urandom);
         #1;
      end
      chk("drained", 0, q.size());
      @(posedge mclk);
      outReady <= 1'b0;
      dataRate <= 16'h3006;
      repeat (40) @(posedge mclk);
      chk("lockHeld", 0, lockLostFlag);
      dataRate <= 16'h3100;
      wait_lock(1'b1);
      wait_lock(1'b0);
      repeat (8) @(posedge mclk);
      summarize();
   end
endmodule
`default_nettype wire
